//--- ogc_chk_sva.sv
// Port checker for the output inhibit control block
`timescale 1ns/10ps
`default_nettype none
module ogc_chk (
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_latch_inhibit_b,
  input wire logic        i_output_toggle_key,
  input wire logic        o_wb_ack,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_output_enable,
  input wire logic        o_inhibit_latched,
  input wire logic [2:0]  o_baud_sel,
  input wire logic [1:0]  o_parity_sel
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_req; i_wb_cyc && i_wb_stb && !o_wb_ack; endsequence
  sequence s_ack; o_wb_ack ##1 !o_wb_ack; endsequence
  AST_ACK_NEXT: assert property (s_req |=> s_ack)
    else $error("ack not a single pulse after request");
  AST_DAT_IDLE: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
    else $error("read data not zero outside ack");
  AST_BAUD_SET: assert property (o_baud_sel <= 3'h4)
    else $error("baud select outside five choices");
  AST_PAR_SET: assert property (o_parity_sel != 2'h3)
    else $error("parity select outside three choices");
  AST_LATCH_OFF: assert property (
    o_inhibit_latched |-> !o_output_enable)
    else $error("output on while inhibit latched");
  AST_LATCH_CAUSE: assert property ($rose(o_inhibit_latched)
    |-> !$past(i_latch_inhibit_b, 3)) else $error("latch set without low pin");
  AST_LATCH_CLR: assert property ($fell(o_inhibit_latched)
    |-> $past(i_output_toggle_key, 2) || $past(i_output_toggle_key, 3)
    || o_wb_ack || $past(o_wb_ack)) else $error("latch cleared without key");
  AST_OUT_ON: assert property ($rose(o_output_enable)
    |-> !o_inhibit_latched) else $error("output on with latch pending");
endmodule : ogc_chk
bind ogc_top ogc_chk i_ogc_chk (.i_clk(i_clk), .i_rst_b(i_rst_b),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_latch_inhibit_b(i_latch_inhibit_b),
  .i_output_toggle_key(i_output_toggle_key), .o_wb_ack(o_wb_ack),
  .o_wb_dat(o_wb_dat), .o_output_enable(o_output_enable),
  .o_inhibit_latched(o_inhibit_latched), .o_baud_sel(o_baud_sel),
  .o_parity_sel(o_parity_sel));
`default_nettype wire

//--- ogc_defs.svh
// Constants for the output inhibit control block
//
// Functional notes
// RULE1: Baud choice is exactly 9600 to 115200, five
// RULE2: Parity choice is even, odd or none
// RULE3: Output off by external input or operator
// RULE4: Latching inhibit has enable and disable setting
// RULE5: Both enables held as configuration settings
// RULE6: Enabled latching inhibit low switches output off
// RULE7: Latched off stays off after input high
// RULE8: Only toggle key clears latch, output on
// RULE9: Enabled level gate low switches output off
// RULE10: Level gate high restores output automatically
// RULE11: Disabled function input never changes output
`ifndef OGC_DEFS_SVH
`define OGC_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OGC_ADR_CTRL     4'h0
`define OGC_ADR_STATUS   4'h4
`define OGC_ADR_CMD      4'h8
`define OGC_ADR_BAUD     4'hc

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define OGC_CTRL_LATCH_EN  0
`define OGC_CTRL_LEVEL_EN  1
`define OGC_CTRL_BAUD_LO   4
`define OGC_CTRL_BAUD_HI   6
`define OGC_CTRL_PAR_LO    8
`define OGC_CTRL_PAR_HI    9

// ----------------------------------------------------------------------
// Command register fields (write one to act, read as zero)
// ----------------------------------------------------------------------
`define OGC_CMD_MANUAL_OFF 0
`define OGC_CMD_TOGGLE_KEY 1

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define OGC_ST_OUTPUT_ON   0
`define OGC_ST_LATCHED     1
`define OGC_ST_LEVEL_OFF   2
`define OGC_ST_INHIBIT_PIN 3
`define OGC_ST_LEVEL_PIN   4
`define OGC_ST_OPERATOR_ON 5

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define OGC_RST_LATCH_EN   1'b0
`define OGC_RST_LEVEL_EN   1'b0
`define OGC_RST_OPER_ON    1'b0
`define OGC_RST_BAUD       3'h4
`define OGC_RST_PARITY     2'h2

// ----------------------------------------------------------------------
// Baud rates in bits per second
// ----------------------------------------------------------------------
`define OGC_BPS_0          32'h0000_2580
`define OGC_BPS_1          32'h0000_4b00
`define OGC_BPS_2          32'h0000_9600
`define OGC_BPS_3          32'h0000_e100
`define OGC_BPS_4          32'h0001_c200

`endif

//--- ogc_pkg.sv
// Types for the output inhibit control block
package ogc_pkg;

  typedef enum logic [2:0] {
    OGC_BAUD_9600   = 3'h0,
    OGC_BAUD_19200  = 3'h1,
    OGC_BAUD_38400  = 3'h2,
    OGC_BAUD_57600  = 3'h3,
    OGC_BAUD_115200 = 3'h4
  } ogc_baud_t;

  typedef enum logic [1:0] {
    OGC_PAR_EVEN = 2'h0,
    OGC_PAR_ODD  = 2'h1,
    OGC_PAR_NONE = 2'h2
  } ogc_parity_t;

  typedef struct packed {
    logic        latch_en;
    logic        level_en;
    ogc_baud_t   baud;
    ogc_parity_t parity;
    logic        oper_on;
    logic        latched;
    logic        key_prev;
    logic        out_on;
    logic        ack;
    logic [31:0] rdat;
  } ogc_state_t;

endpackage : ogc_pkg

//--- ogc_src.sv
// External control source for the rear terminals and operator key
`timescale 1ns/10ps
`default_nettype none
module ogc_src (
  input  wire logic i_clk,
  output logic      o_latch_inhibit_b,
  output logic      o_level_gate,
  output logic      o_key
);
  initial begin
    o_latch_inhibit_b = 1'b1;
    o_level_gate      = 1'b1;
    o_key             = 1'b0;
  end
  task automatic drive(input logic inh_b, input logic lvl);
    @(posedge i_clk);
    o_latch_inhibit_b <= inh_b;
    o_level_gate      <= lvl;
  endtask : drive
  // Random hold, always long enough to pass the pin synchroniser
  task automatic press();
    @(posedge i_clk);
    o_key <= 1'b1;
    repeat (3 + $urandom_range(3)) @(posedge i_clk);
    o_key <= 1'b0;
  endtask : press
endmodule : ogc_src
`default_nettype wire

//--- ogc_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module ogc_sync #(
  parameter int          WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_r <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule : ogc_sync
`default_nettype wire

//--- ogc_top.sv
// Output inhibit control with classic Wishbone register slave
`timescale 1ns/10ps
`default_nettype none
`include "ogc_defs.svh"
module ogc_top (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // Wishbone classic slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [3:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic             o_wb_ack,
  output logic      [31:0] o_wb_dat,
  // Rear terminal and panel pins, asynchronous
  input  wire logic        i_latch_inhibit_b,
  input  wire logic        i_level_output_gate_input,
  input  wire logic        i_output_toggle_key,
  // Output gating and serial settings
  output logic             o_output_enable,
  output logic             o_inhibit_latched,
  output logic      [2:0]  o_baud_sel,
  output logic      [1:0]  o_parity_sel
);

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  logic [2:0] pins_sync;
  logic       inhibit_b_s;
  logic       level_s;
  logic       key_s;

  ogc_sync #(
    .WIDTH   (3),
    .RST_VAL (3'b011)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_async ({i_output_toggle_key, i_level_output_gate_input,
               i_latch_inhibit_b}),
    .o_sync  (pins_sync)
  );

  assign inhibit_b_s = pins_sync[0];
  assign level_s     = pins_sync[1];
  assign key_s       = pins_sync[2];

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  ogc_pkg::ogc_state_t st_r;
  ogc_pkg::ogc_state_t st_nxt;

  logic        bus_req;
  logic        wr;
  logic        key_press;
  logic        manual_off;
  logic        latch_set;
  logic        level_off;
  logic [2:0]  baud_wr;
  logic [1:0]  par_wr;
  logic [31:0] rd_val;

  function automatic logic [31:0] ogc_bps(input ogc_pkg::ogc_baud_t b);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (b)
      ogc_pkg::OGC_BAUD_9600:   v = `OGC_BPS_0;
      ogc_pkg::OGC_BAUD_19200:  v = `OGC_BPS_1;
      ogc_pkg::OGC_BAUD_38400:  v = `OGC_BPS_2;
      ogc_pkg::OGC_BAUD_57600:  v = `OGC_BPS_3;
      ogc_pkg::OGC_BAUD_115200: v = `OGC_BPS_4;
      default:                  v = 32'h0000_0000;
    endcase
    return v;
  endfunction : ogc_bps

  always_comb begin
    st_nxt  = st_r;
    bus_req = i_wb_cyc && i_wb_stb && !st_r.ack;
    wr      = bus_req && i_wb_we;
    baud_wr = i_wb_dat[`OGC_CTRL_BAUD_HI:`OGC_CTRL_BAUD_LO];
    par_wr  = i_wb_dat[`OGC_CTRL_PAR_HI:`OGC_CTRL_PAR_LO];

    // ------------------------------------------------------------------
    // Configuration writes
    // ------------------------------------------------------------------
    if (wr && i_wb_adr == `OGC_ADR_CTRL && i_wb_sel[0]) begin
      st_nxt.latch_en = i_wb_dat[`OGC_CTRL_LATCH_EN]; // [RULE4] [RULE5]
      st_nxt.level_en = i_wb_dat[`OGC_CTRL_LEVEL_EN]; // [RULE5]
      // Codes beyond the five rates are dropped, old choice kept
      if (baud_wr <= 3'h4) begin
        st_nxt.baud = ogc_pkg::ogc_baud_t'(baud_wr); // [RULE1]
      end
    end
    if (wr && i_wb_adr == `OGC_ADR_CTRL && i_wb_sel[1]
        && par_wr != 2'h3) begin
      st_nxt.parity = ogc_pkg::ogc_parity_t'(par_wr); // [RULE2]
    end

    // ------------------------------------------------------------------
    // Operator actions and output gating
    // ------------------------------------------------------------------
    st_nxt.key_prev = key_s;
    key_press  = (key_s && !st_r.key_prev)
               || (wr && i_wb_adr == `OGC_ADR_CMD && i_wb_sel[0]
                   && i_wb_dat[`OGC_CMD_TOGGLE_KEY]);
    manual_off = wr && i_wb_adr == `OGC_ADR_CMD && i_wb_sel[0]
               && i_wb_dat[`OGC_CMD_MANUAL_OFF];
    latch_set  = st_r.latch_en && !inhibit_b_s; // [RULE6] [RULE11]
    level_off  = st_r.level_en && !level_s;     // [RULE9] [RULE11]

    if (latch_set) begin
      // Low pin wins over a key press in the same cycle
      st_nxt.latched = 1'b1; // [RULE6] [RULE7]
      st_nxt.oper_on = 1'b0;
    end else if (key_press && st_r.latched) begin
      st_nxt.latched = 1'b0; // [RULE8]
      st_nxt.oper_on = 1'b1; // [RULE8]
    end else if (key_press) begin
      st_nxt.oper_on = !st_r.oper_on;
    end
    if (manual_off && !key_press) begin
      st_nxt.oper_on = 1'b0; // [RULE3]
    end

    // Level gate only masks, so release restores the output
    st_nxt.out_on = st_nxt.oper_on && !st_nxt.latched
                  && !level_off; // [RULE3] [RULE9] [RULE10]

    // ------------------------------------------------------------------
    // Bus answer: one wait state, unmapped reads zero
    // ------------------------------------------------------------------
    rd_val = 32'h0000_0000;
    unique case (i_wb_adr)
      `OGC_ADR_CTRL: begin
        rd_val[`OGC_CTRL_LATCH_EN] = st_r.latch_en;
        rd_val[`OGC_CTRL_LEVEL_EN] = st_r.level_en;
        rd_val[`OGC_CTRL_BAUD_HI:`OGC_CTRL_BAUD_LO] = st_r.baud;
        rd_val[`OGC_CTRL_PAR_HI:`OGC_CTRL_PAR_LO]   = st_r.parity;
      end
      `OGC_ADR_STATUS: begin
        rd_val[`OGC_ST_OUTPUT_ON]   = st_r.out_on;
        rd_val[`OGC_ST_LATCHED]     = st_r.latched;
        rd_val[`OGC_ST_LEVEL_OFF]   = level_off;
        rd_val[`OGC_ST_INHIBIT_PIN] = inhibit_b_s;
        rd_val[`OGC_ST_LEVEL_PIN]   = level_s;
        rd_val[`OGC_ST_OPERATOR_ON] = st_r.oper_on;
      end
      `OGC_ADR_BAUD: rd_val = ogc_bps(st_r.baud); // [RULE1]
      default:       rd_val = 32'h0000_0000;
    endcase
    st_nxt.ack  = bus_req;
    st_nxt.rdat = (bus_req && !i_wb_we) ? rd_val : 32'h0000_0000;
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r.latch_en <= `OGC_RST_LATCH_EN;
      st_r.level_en <= `OGC_RST_LEVEL_EN;
      st_r.baud     <= ogc_pkg::OGC_BAUD_115200;
      st_r.parity   <= ogc_pkg::OGC_PAR_NONE;
      st_r.oper_on  <= `OGC_RST_OPER_ON;
      st_r.latched  <= 1'b0;
      st_r.key_prev <= 1'b0;
      st_r.out_on   <= 1'b0;
      st_r.ack      <= 1'b0;
      st_r.rdat     <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_wb_ack          = st_r.ack;
  assign o_wb_dat          = st_r.rdat;
  assign o_output_enable   = st_r.out_on;
  assign o_inhibit_latched = st_r.latched;
  assign o_baud_sel        = st_r.baud;
  assign o_parity_sel      = st_r.parity;

endmodule : ogc_top
`default_nettype wire

//--- ogc_top_tb.sv
// Self-checking bench for the output inhibit control block
`timescale 1ns/10ps
`default_nettype none
module ogc_top_tb;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] q, rdat;
  logic        inh_b, lvl, key, ack, oen, lat;
  logic [2:0]  bsel;
  logic [2:0]  eb = 3'h4;
  logic [1:0]  psel;
  logic [1:0]  ep = 2'h2;
  int          err_total = 0;
  int          compares = 0;
  always #2 clk = ~clk;
  ogc_top i_ogc_top (.i_clk(clk), .i_rst_b(rst_b), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf),
    .i_wb_dat(wdat), .o_wb_ack(ack), .o_wb_dat(rdat),
    .i_latch_inhibit_b(inh_b), .i_level_output_gate_input(lvl),
    .i_output_toggle_key(key), .o_output_enable(oen),
    .o_inhibit_latched(lat), .o_baud_sel(bsel), .o_parity_sel(psel));
  ogc_src i_ogc_src (.i_clk(clk), .o_latch_inhibit_b(inh_b),
    .o_level_gate(lvl), .o_key(key));
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  // Called just after an edge; waits for ack with no assumed latency
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1 && n < 16) begin
      @(posedge clk);
      n++;
    end
    if (n == 16) err_total++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  function automatic logic [31:0] cw(input logic [2:0] b,
    input logic [1:0] p, input logic lv, input logic le);
    return {22'h0, p, 1'b0, b, 2'h0, lv, le};
  endfunction : cw
  function automatic logic [31:0] bps(input logic [2:0] c);
    case (c)
      3'h0: return 32'h2580;
      3'h1: return 32'h4b00;
      3'h2: return 32'h9600;
      3'h3: return 32'he100;
      default: return 32'h1c200;
    endcase
  endfunction : bps
  task automatic look(input logic e_on, input logic e_lat);
    repeat (6) @(posedge clk);
    chk("output_enable", {31'h0, e_on}, {31'h0, oen});
    chk("inhibit_latched", {31'h0, e_lat}, {31'h0, lat});
  endtask : look
  initial begin
    #(4 * 20000);
    err_total++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h2f8c));
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    look(1'b0, 1'b0);
    wb(1'b0, 4'h0, 32'h0);
    chk("ctrl", 32'h240, q);
    for (int i = 0; i < 8; i++) begin
      logic [1:0] p;
      p = 2'($urandom_range(3));
      if (i < 5) eb = 3'(i);
      if (p != 2'h3) ep = p;
      wb(1'b1, 4'h0, cw(3'(i), p, 1'b0, 1'b0));
      wb(1'b0, 4'h0, 32'h0);
      chk("ctrl", cw(eb, ep, 1'b0, 1'b0), q);
      wb(1'b0, 4'hc, 32'h0);
      chk("bps", bps(eb), q);
      chk("baud_sel", {29'h0, eb}, {29'h0, bsel});
      chk("parity_sel", {30'h0, ep}, {30'h0, psel});
    end
    wb(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, q);
    i_ogc_src.press();
    look(1'b1, 1'b0);
    i_ogc_src.drive(1'b0, 1'b1);
    look(1'b1, 1'b0);
    i_ogc_src.drive(1'b1, 1'b1);
    wb(1'b1, 4'h0, cw(eb, ep, 1'b0, 1'b1));
    i_ogc_src.drive(1'b0, 1'b1);
    look(1'b0, 1'b1);
    i_ogc_src.drive(1'b1, 1'b1);
    look(1'b0, 1'b1);
    wb(1'b0, 4'h4, 32'h0);
    chk("status", 32'h1a, q);
    i_ogc_src.press();
    look(1'b1, 1'b0);
    wb(1'b1, 4'h8, 32'h1);
    look(1'b0, 1'b0);
    wb(1'b1, 4'h8, 32'h2);
    look(1'b1, 1'b0);
    i_ogc_src.drive(1'b0, 1'b1);
    i_ogc_src.drive(1'b1, 1'b1);
    look(1'b0, 1'b1);
    wb(1'b1, 4'h8, 32'h2);
    look(1'b1, 1'b0);
    wb(1'b1, 4'h0, cw(eb, ep, 1'b1, 1'b0));
    i_ogc_src.drive(1'b1, 1'b0);
    look(1'b0, 1'b0);
    wb(1'b0, 4'h4, 32'h0);
    chk("status", 32'h2c, q);
    i_ogc_src.drive(1'b1, 1'b1);
    look(1'b1, 1'b0);
    wb(1'b1, 4'h0, cw(eb, ep, 1'b0, 1'b0));
    i_ogc_src.drive(1'b1, 1'b0);
    look(1'b1, 1'b0);
    end_of_test();
  end
endmodule : ogc_top_tb
`default_nettype wire
